// ===== common/ppcs_pkg.sv
// ppcs_pkg: constants for the per-port phy control and status register bank.
// assumes an 8-bit management register port with byte offsets as listed here.
`default_nettype none
package ppcs_pkg;
    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] PPCS_P1_ADV_OFS = 8'h2C;
    localparam logic [7:0] PPCS_P1_CTL_OFS = 8'h2D;
    localparam logic [7:0] PPCS_P1_STA_OFS = 8'h2E;
    localparam logic [7:0] PPCS_P2_ADV_OFS = 8'h3C;
    localparam logic [7:0] PPCS_P2_CTL_OFS = 8'h3D;
    localparam logic [7:0] PPCS_P2_STA_OFS = 8'h3E;
    localparam logic [7:0] PPCS_P3_CTL_OFS = 8'h4D;
    localparam logic [7:0] PPCS_P4_CTL_OFS = 8'h5D;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int PPCS_ADV_10FD_BIT = 1;
    localparam int PPCS_ADV_10HD_BIT = 0;
    localparam int PPCS_CTL_LED_OFF_BIT = 7;
    localparam int PPCS_CTL_TX_DIS_BIT = 6;
    localparam int PPCS_CTL_AN_RESTART_BIT = 5;
    localparam int PPCS_CTL_RSVD_BIT = 4;
    localparam int PPCS_CTL_PWR_DOWN_BIT = 3;
    localparam int PPCS_CTL_MDIX_DIS_BIT = 2;
    localparam int PPCS_CTL_FORCE_MDI_BIT = 1;
    localparam int PPCS_CTL_MAC_LOOP_BIT = 0;
    localparam int PPCS_STA_MDI_BIT = 7;
    localparam int PPCS_STA_AN_DONE_BIT = 6;
    localparam int PPCS_STA_LINK_BIT = 5;

    // -------------------------------------------------------------------
    // reset values and masks
    // -------------------------------------------------------------------
    localparam logic [1:0] PPCS_ADV_RST = 2'h3;
    localparam logic [7:0] PPCS_CTL_RST = 8'h00;
    localparam logic [7:0] PPCS_CTL_WMASK = 8'hEF;
    localparam logic [7:0] PPCS_RDATA_RST = 8'h00;
    localparam logic [1:0] PPCS_LED_RST = 2'h0;
    localparam int PPCS_NPORTS = 2;
    // port number that serves as monitor for port 3 and 4 mac loopback
    localparam logic [2:0] PPCS_MONITOR_PORT = 3'h2;
endpackage : ppcs_pkg
`default_nettype wire

// ===== src/ppcs_port.sv
// ppcs_port: advertisement and control 6 register of one phy port.
// assumes decoded one-cycle write strobes from the register bank top.
`default_nettype none
module ppcs_port
    import ppcs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register writes
    input wire logic wr_adv,
    input wire logic wr_ctl,
    input wire logic [7:0] wdata,
    // raw led drive from the link/activity logic
    input wire logic [1:0] led_in,
    // register contents and phy controls
    output logic [1:0] adv_q,
    output logic [7:0] ctl_q,
    output logic [1:0] led_q,
    output logic autoneg_restart_q
);
    // -------------------------------------------------------------------
    // advertised 10bt capability
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            adv_q <= PPCS_ADV_RST;
        end else if (wr_adv) begin
            adv_q[1] <= wdata[PPCS_ADV_10FD_BIT];
            adv_q[0] <= wdata[PPCS_ADV_10HD_BIT];
        end
    end

    // -------------------------------------------------------------------
    // control 6
    // -------------------------------------------------------------------
    // restart bit clears itself one cycle after it is seen; a fresh write of
    // one in that same cycle wins, so no request is lost
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= PPCS_CTL_RST;
        end else if (wr_ctl) begin
            ctl_q <= wdata & PPCS_CTL_WMASK;
        end else begin
            ctl_q[PPCS_CTL_AN_RESTART_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            autoneg_restart_q <= 1'b0;
        end else begin
            autoneg_restart_q <= ctl_q[PPCS_CTL_AN_RESTART_BIT];
        end
    end

    // -------------------------------------------------------------------
    // led blanking
    // -------------------------------------------------------------------
    // blanked leds are driven high, which is the off level of these pins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            led_q <= PPCS_LED_RST;
        end else begin
            led_q <= ctl_q[PPCS_CTL_LED_OFF_BIT] ? 2'h3 : led_in;
        end
    end
endmodule // ppcs_port
`default_nettype wire

// ===== src/ppcs_top.sv
// ppcs_top: per-port phy control and status register bank of the switch.
// assumes a synchronous management register port on clk_sys with one-cycle
// read and write strobes; read data is returned the cycle after the strobe.
// status inputs and raw led drive are taken as synchronous to clk_sys.
//
// Behaviour
// - advertisement bit 1 (reset one) advertises 10bt full duplex, zero suppresses it.
// - advertisement bit 0 (reset one) advertises 10bt half duplex, zero omits it.
// - control bit 7 set drives both port leds high (off), clear lets them run normally.
// - control bit 6 set disables the port transmitter, reset zero.
// - writing one to control bit 5 restarts auto-negotiation and the bit clears itself.
// - control bit 3 set powers the port down, reset zero.
// - control bit 2 set disables automatic mdi/mdi-x crossover, zero keeps it on.
// - with crossover off, control bit 1 one forces mdi and zero forces mdi-x.
// - control bit 0 set loops frames back at the port mac.
// - bit 0 at 0x4D or 0x5D loops port 3 or port 4 at its mac with port 2 as monitor.
// - status bit 7 reads one for mdi and zero for mdi-x.
// - status bit 6 reads one once auto-negotiation is done, reset zero.
// - status bit 5 reads one while the link is good, reset zero.
`default_nettype none
module ppcs_top
    import ppcs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // management register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // phy state of ports 1 and 2
    input wire logic [1:0] mdi_state,
    input wire logic [1:0] autoneg_done,
    input wire logic [1:0] link_good,
    // raw led drive, two per port
    input wire logic [1:0] port1_led_in,
    input wire logic [1:0] port2_led_in,
    // led pins
    output logic [1:0] port1_led_out,
    output logic [1:0] port2_led_out,
    // phy controls of ports 1 and 2
    output logic [1:0] adv_10fd,
    output logic [1:0] adv_10hd,
    output logic [1:0] tx_disable,
    output logic [1:0] autoneg_restart,
    output logic [1:0] power_down,
    output logic [1:0] auto_mdix_en,
    output logic [1:0] force_mdi,
    output logic [1:0] mdi_select,
    // mac loopback of ports 1 to 4, bit 0 is port 1
    output logic [3:0] mac_loopback,
    output logic [2:0] loop_monitor_port
);
    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    function automatic logic ppcs_hit(input logic [7:0] a, input logic [7:0] ofs);
        ppcs_hit = (a == ofs);
    endfunction

    // write strobe for one register offset
    function automatic logic ppcs_wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        ppcs_wr_hit = wr && ppcs_hit(a, ofs);
    endfunction

    // ports 3 and 4 keep only bit 0; the upper bits read zero
    function automatic logic [7:0] ppcs_loop_byte(input logic loop_bit);
        ppcs_loop_byte = {7'h00, loop_bit};
    endfunction

    logic [7:0] adv_ofs [PPCS_NPORTS];
    logic [7:0] ctl_ofs [PPCS_NPORTS];
    logic [7:0] sta_ofs [PPCS_NPORTS];
    assign adv_ofs[0] = PPCS_P1_ADV_OFS;
    assign adv_ofs[1] = PPCS_P2_ADV_OFS;
    assign ctl_ofs[0] = PPCS_P1_CTL_OFS;
    assign ctl_ofs[1] = PPCS_P2_CTL_OFS;
    assign sta_ofs[0] = PPCS_P1_STA_OFS;
    assign sta_ofs[1] = PPCS_P2_STA_OFS;

    logic [1:0] adv_q [PPCS_NPORTS];
    logic [7:0] ctl_q [PPCS_NPORTS];
    logic [1:0] led_q [PPCS_NPORTS];
    logic [1:0] led_in [PPCS_NPORTS];
    logic [PPCS_NPORTS-1:0] restart_q;
    logic [2:0] sta_q [PPCS_NPORTS];
    logic [1:0] far_loop_q;

    assign led_in[0] = port1_led_in;
    assign led_in[1] = port2_led_in;

    // -------------------------------------------------------------------
    // per-port registers
    // -------------------------------------------------------------------
    for (genvar p = 0; p < PPCS_NPORTS; p++) begin : g_port
        ppcs_port u_port (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .wr_adv(reg_wr && ppcs_hit(reg_addr, adv_ofs[p])),
            .wr_ctl(reg_wr && ppcs_hit(reg_addr, ctl_ofs[p])),
            .wdata(reg_wdata),
            .led_in(led_in[p]),
            .adv_q(adv_q[p]),
            .ctl_q(ctl_q[p]),
            .led_q(led_q[p]),
            .autoneg_restart_q(restart_q[p])
        );

        // status sampled each cycle, reads show the sampled value
        // a pin change shorter than one read interval can be missed by polling
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                sta_q[p] <= 3'h0;
            end else begin
                sta_q[p] <= {mdi_state[p], autoneg_done[p], link_good[p]};
            end
        end

        // control outputs are re-registered so every pin comes from a flop
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                adv_10fd[p] <= PPCS_ADV_RST[1];
                adv_10hd[p] <= PPCS_ADV_RST[0];
                tx_disable[p] <= 1'b0;
                power_down[p] <= 1'b0;
                auto_mdix_en[p] <= 1'b1;
                force_mdi[p] <= 1'b0;
                mdi_select[p] <= 1'b0;
                mac_loopback[p] <= 1'b0;
            end else begin
                adv_10fd[p] <= adv_q[p][1];
                adv_10hd[p] <= adv_q[p][0];
                tx_disable[p] <= ctl_q[p][PPCS_CTL_TX_DIS_BIT];
                power_down[p] <= ctl_q[p][PPCS_CTL_PWR_DOWN_BIT];
                auto_mdix_en[p] <= !ctl_q[p][PPCS_CTL_MDIX_DIS_BIT];
                force_mdi[p] <= ctl_q[p][PPCS_CTL_FORCE_MDI_BIT];
                // pair in use: forced value when auto is off, else detected state
                mdi_select[p] <= ctl_q[p][PPCS_CTL_MDIX_DIS_BIT]
                    ? ctl_q[p][PPCS_CTL_FORCE_MDI_BIT] : mdi_state[p];
                mac_loopback[p] <= ctl_q[p][PPCS_CTL_MAC_LOOP_BIT];
            end
        end
    end

    // -------------------------------------------------------------------
    // led pins and restart pulses
    // -------------------------------------------------------------------
    // plain wires onto flops inside ppcs_port, so these pins stay registered
    assign port1_led_out = led_q[0];
    assign port2_led_out = led_q[1];
    assign autoneg_restart = restart_q;

    // -------------------------------------------------------------------
    // ports 3 and 4: only the mac loopback bit exists
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            far_loop_q <= 2'h0;
        end else begin
            // a write to one far port leaves the other port's bit as it was
            if (ppcs_wr_hit(reg_wr, reg_addr, PPCS_P3_CTL_OFS)) begin
                far_loop_q[0] <= reg_wdata[PPCS_CTL_MAC_LOOP_BIT];
            end
            if (ppcs_wr_hit(reg_wr, reg_addr, PPCS_P4_CTL_OFS)) begin
                far_loop_q[1] <= reg_wdata[PPCS_CTL_MAC_LOOP_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mac_loopback[3:2] <= 2'h0;
            loop_monitor_port <= 3'h0;
        end else begin
            mac_loopback[3:2] <= far_loop_q;
            // port 2 monitors whenever port 3 or 4 is looped
            // the monitor number is fixed; zero means no far port is looped
            loop_monitor_port <= (far_loop_q != 2'h0) ? PPCS_MONITOR_PORT : 3'h0;
        end
    end

    // -------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = PPCS_RDATA_RST;
        // later matches override earlier ones; the offsets never overlap
        for (int p = 0; p < PPCS_NPORTS; p++) begin
            if (ppcs_hit(reg_addr, adv_ofs[p])) begin
                rd_mux = {6'h00, adv_q[p]};
            end
            if (ppcs_hit(reg_addr, ctl_ofs[p])) begin
                rd_mux = ctl_q[p];
            end
            if (ppcs_hit(reg_addr, sta_ofs[p])) begin
                rd_mux = {sta_q[p], 5'h00};
            end
        end
        if (ppcs_hit(reg_addr, PPCS_P3_CTL_OFS)) begin
            rd_mux = ppcs_loop_byte(far_loop_q[0]);
        end
        if (ppcs_hit(reg_addr, PPCS_P4_CTL_OFS)) begin
            rd_mux = ppcs_loop_byte(far_loop_q[1]);
        end
    end

    // a read in the same cycle as a write to that offset returns the old
    // byte, because the mux looks at the registers before the edge; the
    // trade is one cycle of latency for a read path free of write bypass
    // unmapped offsets read zero; data holds until the next read
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= PPCS_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end
endmodule // ppcs_top
`default_nettype wire

// ===== verification/ppcs_top_monitor.sv
// ppcs_top_monitor: port-level assertions for the phy control/status bank.
// assumes the bind at the foot of this file and a single clk_sys domain.
`default_nettype none
module ppcs_top_monitor
    import ppcs_pkg::*;
(
    // clock, reset and register port
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // phy state and controls
    input wire logic [1:0] mdi_state,
    input wire logic [1:0] autoneg_done,
    input wire logic [1:0] link_good,
    input wire logic [1:0] port1_led_out,
    input wire logic [1:0] adv_10fd,
    input wire logic [1:0] adv_10hd,
    input wire logic [1:0] tx_disable,
    input wire logic [1:0] autoneg_restart,
    input wire logic [1:0] power_down,
    input wire logic [1:0] auto_mdix_en,
    input wire logic [1:0] force_mdi,
    input wire logic [3:0] mac_loopback
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic w2d;
    logic w3d;
    assign w2d = reg_wr && reg_addr == 8'h2D;
    assign w3d = reg_wr && reg_addr == 8'h3D;
    AST_TXDIS: assert property (w2d |-> ##2 tx_disable[0] == $past(reg_wdata[6], 2))
        else $error("tx disable does not follow control write");
    AST_RESTART: assert property (w2d && reg_wdata[5] ##1 !w2d |-> ##1 autoneg_restart[0] ##1 !autoneg_restart[0])
        else $error("restart pulse missing or too long");
    AST_LED: assert property (w2d && reg_wdata[7] |-> ##2 port1_led_out == 2'h3)
        else $error("leds not driven high");
    AST_PWR: assert property (w3d |-> ##2 power_down[1] == $past(reg_wdata[3], 2))
        else $error("power down does not follow control write");
    AST_MDIX: assert property (w3d |-> ##2 auto_mdix_en[1] == !$past(reg_wdata[2], 2) && force_mdi[1] == $past(reg_wdata[1], 2))
        else $error("crossover controls wrong");
    AST_ADV: assert property (reg_wr && reg_addr == 8'h3C |-> ##2 {adv_10fd[1], adv_10hd[1]} == $past(reg_wdata[1:0], 2))
        else $error("advertisement outputs wrong");
    AST_LOOP: assert property (reg_wr && reg_addr == 8'h4D |-> ##2 mac_loopback[2] == $past(reg_wdata[0], 2))
        else $error("port 3 loopback wrong");
    AST_STA: assert property ($past(nrst) && reg_rd && reg_addr == 8'h2E |=> reg_rdata == {$past(mdi_state[0], 2), $past(autoneg_done[0], 2), $past(link_good[0], 2), 5'h00})
        else $error("status read wrong");
    AST_RSVD: assert property (reg_rd && reg_addr == 8'h3D |=> !reg_rdata[4])
        else $error("reserved control bit reads one");
    COV_RESTART: cover property (autoneg_restart[0]);
    COV_LOOP: cover property (mac_loopback[3]);
    COV_LED: cover property (w2d && reg_wdata[7]);
endmodule // ppcs_top_monitor
bind ppcs_top ppcs_top_monitor i_mon (.*);
`default_nettype wire

// ===== verification/ppcs_host.sv
// ppcs_host: management host model issuing single-byte register cycles.
// assumes fixed one-cycle read latency and no handshake on the port.
`default_nettype none
module ppcs_host (
    // clock
    input wire logic clk_sys,
    // management register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // restart requests are plain writes of one to control bit 5
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        // released data no longer shows the written byte
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule // ppcs_host
`default_nettype wire

// ===== verification/tb.sv
// tb: self-checking bench for ppcs_top, random data from a fixed seed.
// assumes ppcs_host drives the register port and the monitor is bound.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ppcs_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r;
    logic reg_wr, reg_rd;
    logic [1:0] mdi_state = 2'h0, autoneg_done = 2'h0, link_good = 2'h0, port1_led_in = 2'h0, port2_led_in = 2'h0;
    logic [1:0] port1_led_out, port2_led_out, adv_10fd, adv_10hd, tx_disable, autoneg_restart, power_down;
    logic [1:0] auto_mdix_en, force_mdi, mdi_select, lp;
    logic [3:0] mac_loopback;
    logic [2:0] loop_monitor_port;
    int miscompares = 0;
    int num_checks = 0;
    int p;
    always #2 clk_sys = ~clk_sys;
    ppcs_top i_dut (.*);
    ppcs_host i_host (.*);
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // restart self-clears and bit 4 never holds a one
    function automatic logic [7:0] ctl_exp(input logic [7:0] w);
        return w & 8'hCF;
    endfunction
    function automatic logic sel_exp(input logic [7:0] w, input logic m);
        return w[2] ? w[1] : m;
    endfunction
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        v = $urandom(32'h89CA);
        lp = 2'h0;
        cyc(16);
        nrst = 1'b1;
        cyc(1);
        chk("rst_out", {adv_10fd, adv_10hd, auto_mdix_en, tx_disable}, 8'hFC);
        i_host.rd(8'h2C, r);
        chk("adv_rst", r, 8'h03);
        i_host.rd(8'h2E, r);
        chk("sta_rst", r, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            p = i % 2;
            v = (i < 2) ? 8'hFF : 8'($urandom);
            {mdi_state, port1_led_in, port2_led_in} = 6'($urandom);
            i_host.wr(p ? 8'h3D : 8'h2D, v);
            cyc(1);
            chk("restart", 8'(autoneg_restart[p]), 8'(v[5]));
            cyc(1);
            chk("restart_end", 8'(autoneg_restart[p]), 8'h00);
            cyc(2);
            chk("ctl_out", 8'({tx_disable[p], power_down[p], auto_mdix_en[p], force_mdi[p], mdi_select[p], mac_loopback[p]}),
                8'({v[6], v[3], !v[2], v[1], sel_exp(v, mdi_state[p]), v[0]}));
            chk("led", 8'(p ? port2_led_out : port1_led_out), 8'(v[7] ? 2'h3 : (p ? port2_led_in : port1_led_in)));
            i_host.rd(p ? 8'h3D : 8'h2D, r);
            chk("ctl_rd", r, ctl_exp(v));
        end
        $display("test control done");
        for (int i = 0; i < 8; i++) begin
            p = i % 2;
            v = (i < 2) ? 8'h00 : 8'($urandom);
            i_host.wr(p ? 8'h3C : 8'h2C, v);
            cyc(2);
            chk("adv_out", 8'({adv_10fd[p], adv_10hd[p]}), 8'(v[1:0]));
            i_host.rd(p ? 8'h3C : 8'h2C, r);
            chk("adv_rd", r, v & 8'h03);
        end
        $display("test advertisement done");
        for (int i = 0; i < 8; i++) begin
            p = i % 2;
            {mdi_state, autoneg_done, link_good} = 6'($urandom);
            i_host.wr(p ? 8'h3E : 8'h2E, 8'hFF);
            i_host.rd(p ? 8'h3E : 8'h2E, r);
            chk("status", r, {mdi_state[p], autoneg_done[p], link_good[p], 5'h00});
        end
        $display("test status done");
        for (int i = 0; i < 6; i++) begin
            v = (i < 2) ? 8'hFF : 8'($urandom);
            lp[i % 2] = v[0];
            i_host.wr((i % 2) ? 8'h5D : 8'h4D, v);
            cyc(3);
            chk("loop", {mac_loopback[3:2], 3'h0, loop_monitor_port}, {lp, 3'h0, (lp != 2'h0) ? 3'h2 : 3'h0});
            i_host.rd((i % 2) ? 8'h5D : 8'h4D, r);
            chk("loop_rd", r, {7'h00, v[0]});
        end
        i_host.rd(8'h10, r);
        chk("unmapped", r, 8'h00);
        $display("test loopback done");
        final_report();
    end
    // whole run is a few hundred cycles; this span is far beyond it
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
endmodule // tb
`default_nettype wire
